// *** core/iec_top.sv ***
// The address-and-strobe port and the register addresses are this design's own decisions.
`include "iec_regs.svh"

module iec_top (
    input wire logic clk, // 40 mhz
    input wire logic rst_n, // sync reset
    input wire logic [7:0] reg_addr, // word index
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // valid cycle after read
    input wire logic [`IEC_N_DED-1:0] src_req, // dedicated source pulses
    input wire logic [4*`IEC_N_SH-1:0] sh_src, // 4 candidates per shared node
    input wire logic [3:0] eru_pin, // async request pins
    output logic [3:0] eru_out, // gated router events
    input wire logic [`IEC_HWTRAPS-1:0] hw_trap, // hardware trap pulses
    input wire logic [2:0] esr_pin, // async service request pins
    input wire logic swi_valid, // software trap pulse
    input wire logic [7:0] swi_num, // software trap number
    input wire logic [3:0] cpu_lvl, // current cpu level
    input wire logic jump_cache, // jump cache in use
    input wire logic trap_end, // trap service returned
    output logic cpu_suspend, // response in progress
    output logic vec_valid, // vector pulse
    output logic [7:0] vec_num, // vector number
    output logic pec_steal, // stolen cycle pulse
    output iec_pkg::iec_xfer_t pec_xfer // transfer descriptor
);
    import iec_pkg::*;

    iec_node_t node_r [`IEC_NODES];
    logic [15:0] pcfg_r [`IEC_PEC_CH];
    logic [15:0] psrc_r [`IEC_PEC_CH];
    logic [15:0] pdst_r [`IEC_PEC_CH];
    logic [15:0] shsel_r, etl_r, ogsel_r, ogpat_r, ogmode_r, tfr_r, esr_r;
    logic [15:0] trap_pend_r, rdata_r;
    logic [3:0] eru_s1_r, eru_s2_r, eru_prev_r, eru_out_r;
    logic [2:0] esr_s1_r, esr_s2_r, esr_prev_r;
    logic swi_pend_r, trap_act_r, vec_valid_r, pec_steal_r;
    logic [7:0] swi_num_r, vec_pend_r, vec_num_r;
    logic [3:0] trap_id_r, lat_r;
    iec_state_t state_r;
    iec_xfer_t xfer_r;

    logic [3:0] etl_evt, ogu_evt;
    logic [`IEC_NODES-1:0] node_evt;
    logic [`IEC_TRAPS-1:0] trap_evt;
    logic sr0_evt, sr1_evt;
    logic best_ok, trap_hit, take_trap, take_swi, take_node, take_pec, keep_req;
    logic [6:0] best_idx;
    logic [3:0] best_pri, trap_idx;
    logic [2:0] ch;
    logic [7:0] cnt_nxt;

    // two-stage synchronisers; stage two and its one-cycle-delayed copy feed logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eru_s1_r <= 4'h0;
            eru_s2_r <= 4'h0;
            eru_prev_r <= 4'h0;
            esr_s1_r <= 3'h0;
            esr_s2_r <= 3'h0;
            esr_prev_r <= 3'h0;
        end else begin
            eru_s1_r <= eru_pin;
            eru_s2_r <= eru_s1_r;
            eru_prev_r <= eru_s2_r;
            esr_s1_r <= esr_pin;
            esr_s2_r <= esr_s1_r;
            esr_prev_r <= esr_s2_r;
        end
    end

    // router: edge channels, then gating units
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            etl_evt[k] = (etl_r[2*k] & eru_s2_r[k] & ~eru_prev_r[k])
                | (etl_r[2*k+1] & ~eru_s2_r[k] & eru_prev_r[k]);
        end
        for (int k = 0; k < 4; k++) begin
            logic comb_evt;
            logic hit;
            comb_evt = |(ogsel_r[4*k+:4] & etl_evt);
            hit = &(eru_s2_r | ~ogpat_r[4*k+:4]);
            unique case (ogmode_r[2*k+:2])
                `IEC_OG_PASS: ogu_evt[k] = comb_evt;
                `IEC_OG_MATCH: ogu_evt[k] = comb_evt & hit;
                `IEC_OG_MISS: ogu_evt[k] = comb_evt & ~hit;
                default: ogu_evt[k] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eru_out_r <= 4'h0;
        end else begin
            eru_out_r <= ogu_evt;
        end
    end

    // hardware events per node
    always_comb begin
        node_evt[`IEC_N_DED-1:0] = src_req;
        node_evt[`IEC_ERU_BASE+:4] = ogu_evt;
        for (int i = 0; i < `IEC_N_SH; i++) begin
            node_evt[`IEC_SH_BASE+i] = sh_src[4*i + int'(shsel_r[2*i+:2])];
        end
    end

    // system requests and trap events
    always_comb begin
        logic [2:0] rise;
        rise = esr_s2_r & ~esr_prev_r & esr_r[`IEC_ESR_EN];
        sr0_evt = |(rise & ~esr_r[`IEC_ESR_CLS]);
        sr1_evt = |(rise & esr_r[`IEC_ESR_CLS]);
        trap_evt = {sr0_evt, sr1_evt, hw_trap};
    end

    // highest priority above cpu level, lowest index on a tie
    always_comb begin
        best_pri = cpu_lvl;
        best_ok = 1'b0;
        best_idx = 7'h00;
        for (int i = 0; i < `IEC_NODES; i++) begin
            if (node_r[i].en && node_r[i].req && node_r[i].pri > best_pri) begin
                best_pri = node_r[i].pri;
                best_idx = 7'(i);
                best_ok = 1'b1;
            end
        end
    end

    // higher trap index is higher priority
    always_comb begin
        trap_idx = 4'h0;
        for (int i = 0; i < `IEC_TRAPS; i++) begin
            if (trap_pend_r[i]) begin
                trap_idx = 4'(i);
            end
        end
        trap_hit = |trap_pend_r && (!trap_act_r || trap_idx > trap_id_r);
    end

    always_comb begin
        logic [15:0] cfg;
        ch = node_r[best_idx].ch;
        cfg = pcfg_r[ch];
        take_trap = (state_r == ST_IDLE) && trap_hit;
        take_swi = (state_r == ST_IDLE) && !trap_hit && !trap_act_r && swi_pend_r;
        // nothing below a running trap gets serviced
        take_node = (state_r == ST_IDLE) && !trap_hit && !trap_act_r && !swi_pend_r && best_ok;
        take_pec = take_node && node_r[best_idx].event_transfer_channel
            && (cfg[`IEC_P_CONT] || cfg[`IEC_P_CNT] != 8'h00);
        cnt_nxt = cfg[`IEC_P_CONT] ? cfg[`IEC_P_CNT] : cfg[`IEC_P_CNT] - 8'h01;
        // last transfer leaves the flag up so the node interrupts next
        keep_req = take_pec && !cfg[`IEC_P_CONT] && cnt_nxt == 8'h00;
    end

    // node control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `IEC_NODES; i++) begin
                node_r[i] <= iec_node_t'(10'h000);
            end
        end else begin
            for (int i = 0; i < `IEC_NODES; i++) begin
                if (reg_wr && reg_addr == 8'(i)) begin
                    node_r[i] <= iec_node_t'(reg_wdata[`IEC_NODE_W]);
                    node_r[i].req <= reg_wdata[5] | node_evt[i];
                end else if (take_node && best_idx == 7'(i)) begin
                    node_r[i].req <= keep_req | node_evt[i];
                end else begin
                    node_r[i].req <= node_r[i].req | node_evt[i];
                end
            end
        end
    end

    // event transfer channels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int c = 0; c < `IEC_PEC_CH; c++) begin
                pcfg_r[c] <= `IEC_RST16;
                psrc_r[c] <= `IEC_RST16;
                pdst_r[c] <= `IEC_RST16;
            end
        end else begin
            for (int c = 0; c < `IEC_PEC_CH; c++) begin
                logic [15:0] step;
                step = pcfg_r[c][`IEC_P_BYTE] ? `IEC_STEP_B : `IEC_STEP_W;
                if (reg_wr && reg_addr == `IEC_A_PCFG + 8'(c)) begin
                    pcfg_r[c] <= reg_wdata;
                end else if (take_pec && ch == 3'(c)) begin
                    pcfg_r[c][`IEC_P_CNT] <= cnt_nxt;
                end
                if (reg_wr && reg_addr == `IEC_A_PSRC + 8'(c)) begin
                    psrc_r[c] <= reg_wdata;
                end else if (take_pec && ch == 3'(c) && pcfg_r[c][`IEC_P_SINC]) begin
                    psrc_r[c] <= psrc_r[c] + step;
                end
                if (reg_wr && reg_addr == `IEC_A_PDST + 8'(c)) begin
                    pdst_r[c] <= reg_wdata;
                end else if (take_pec && ch == 3'(c) && pcfg_r[c][`IEC_P_DINC]) begin
                    pdst_r[c] <= pdst_r[c] + step;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pec_steal_r <= 1'b0;
            xfer_r <= iec_xfer_t'(36'h0);
        end else begin
            pec_steal_r <= take_pec;
            if (take_pec) begin
                xfer_r <= {psrc_r[ch], pdst_r[ch], pcfg_r[ch][`IEC_P_BYTE], ch};
            end
        end
    end

    // router and shared-node configuration
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shsel_r <= `IEC_RST16;
            etl_r <= `IEC_RST16;
            ogsel_r <= `IEC_RST16;
            ogpat_r <= `IEC_RST16;
            ogmode_r <= `IEC_RST16;
            esr_r <= `IEC_RST16;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `IEC_A_SHSEL: shsel_r <= reg_wdata;
                `IEC_A_ETL: etl_r <= reg_wdata;
                `IEC_A_OGSEL: ogsel_r <= reg_wdata;
                `IEC_A_OGPAT: ogpat_r <= reg_wdata;
                `IEC_A_OGMODE: ogmode_r <= reg_wdata;
                `IEC_A_ESR: esr_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // trap flags: write one clears, a new trap wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tfr_r <= `IEC_RST16;
            trap_pend_r <= `IEC_RST16;
            trap_act_r <= 1'b0;
            trap_id_r <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == `IEC_A_TFR) begin
                tfr_r <= (tfr_r & ~reg_wdata) | trap_evt;
            end else begin
                tfr_r <= tfr_r | trap_evt;
            end
            if (take_trap) begin
                trap_pend_r <= (trap_pend_r & ~(16'h0001 << trap_idx)) | trap_evt;
                trap_act_r <= 1'b1;
                trap_id_r <= trap_idx;
            end else begin
                trap_pend_r <= trap_pend_r | trap_evt;
                if (trap_end) begin
                    trap_act_r <= 1'b0;
                end
            end
        end
    end

    // software trap held until the response engine is free
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            swi_pend_r <= 1'b0;
            swi_num_r <= 8'h00;
        end else if (take_swi) begin
            swi_pend_r <= 1'b0;
        end else if (swi_valid && !swi_pend_r) begin
            swi_pend_r <= 1'b1;
            swi_num_r <= swi_num;
        end
    end

    // response engine: suspend, count latency, emit vector
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            lat_r <= 4'h0;
            vec_pend_r <= 8'h00;
            vec_valid_r <= 1'b0;
            vec_num_r <= 8'h00;
        end else begin
            vec_valid_r <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (take_trap || take_swi || (take_node && !take_pec)) begin
                        state_r <= ST_RESP;
                        lat_r <= (jump_cache ? `IEC_LAT_JC : `IEC_LAT_NOJC) - 4'h1;
                        if (take_trap) begin
                            vec_pend_r <= {4'h0, trap_idx};
                        end else if (take_swi) begin
                            vec_pend_r <= swi_num_r;
                        end else begin
                            vec_pend_r <= `IEC_VEC_NODE + {1'b0, best_idx};
                        end
                    end
                end
                ST_RESP: begin
                    if (lat_r == 4'h0) begin
                        state_r <= ST_IDLE;
                        vec_valid_r <= 1'b1;
                        vec_num_r <= vec_pend_r;
                    end else begin
                        lat_r <= lat_r - 4'h1;
                    end
                end
            endcase
        end
    end

    // read port; data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= `IEC_RST16;
        end else if (!reg_rd) begin
            rdata_r <= `IEC_RST16;
        end else if (reg_addr < `IEC_A_PCFG) begin
            rdata_r <= {6'h00, node_r[reg_addr[6:0]]};
        end else if (reg_addr < `IEC_A_PSRC) begin
            rdata_r <= pcfg_r[reg_addr[2:0]];
        end else if (reg_addr < `IEC_A_PDST) begin
            rdata_r <= psrc_r[reg_addr[2:0]];
        end else if (reg_addr < `IEC_A_SHSEL) begin
            rdata_r <= pdst_r[reg_addr[2:0]];
        end else begin
            unique case (reg_addr)
                `IEC_A_SHSEL: rdata_r <= shsel_r;
                `IEC_A_ETL: rdata_r <= etl_r;
                `IEC_A_OGSEL: rdata_r <= ogsel_r;
                `IEC_A_OGPAT: rdata_r <= ogpat_r;
                `IEC_A_OGMODE: rdata_r <= ogmode_r;
                `IEC_A_TFR: rdata_r <= tfr_r;
                `IEC_A_ESR: rdata_r <= esr_r;
                `IEC_A_STAT: rdata_r <= {trap_act_r, state_r == ST_RESP, swi_pend_r, 9'h000, trap_id_r};
                default: rdata_r <= `IEC_RST16;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign eru_out = eru_out_r;
    assign cpu_suspend = (state_r == ST_RESP);
    assign vec_valid = vec_valid_r;
    assign vec_num = vec_num_r;
    assign pec_steal = pec_steal_r;
    assign pec_xfer = xfer_r;

endmodule

// *** core/iec_regs.svh ***
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

`define IEC_NODES 96
`define IEC_N_DED 84
`define IEC_ERU_BASE 84
`define IEC_SH_BASE 88
`define IEC_N_SH 8
`define IEC_PEC_CH 8
`define IEC_HWTRAPS 14
`define IEC_TRAPS 16

`define IEC_A_PCFG 8'h60
`define IEC_A_PSRC 8'h68
`define IEC_A_PDST 8'h70
`define IEC_A_SHSEL 8'h78
`define IEC_A_ETL 8'h79
`define IEC_A_OGSEL 8'h7a
`define IEC_A_OGPAT 8'h7b
`define IEC_A_OGMODE 8'h7c
`define IEC_A_TFR 8'h7d
`define IEC_A_ESR 8'h7e
`define IEC_A_STAT 8'h7f

`define IEC_NODE_W 9:0
`define IEC_P_CNT 7:0
`define IEC_P_SINC 8
`define IEC_P_DINC 9
`define IEC_P_BYTE 10
`define IEC_P_CONT 11
`define IEC_ESR_EN 2:0
`define IEC_ESR_CLS 5:3

`define IEC_OG_PASS 2'h0
`define IEC_OG_MATCH 2'h1
`define IEC_OG_MISS 2'h2

`define IEC_LAT_JC 4'h7
`define IEC_LAT_NOJC 4'hb
`define IEC_VEC_NODE 8'h10
`define IEC_STEP_B 16'h0001
`define IEC_STEP_W 16'h0002
`define IEC_RST16 16'h0000

`endif

// *** core/iec_pkg.sv ***
`include "iec_regs.svh"

package iec_pkg;

    typedef struct packed {
        logic [2:0] ch;
        logic event_transfer_channel;
        logic req;
        logic en;
        logic [3:0] pri;
    } iec_node_t;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic byte_mode;
        logic [2:0] ch;
    } iec_xfer_t;

    typedef enum logic [0:0] {ST_IDLE, ST_RESP} iec_state_t;

endpackage

// *** tb/iec_sva.sv ***
module iec_sva
    import iec_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst_n, // sync reset
    input wire logic [7:0] reg_addr, // address
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic jump_cache, // latency select
    input wire logic cpu_suspend, // busy level
    input wire logic vec_valid, // vector pulse
    input wire logic [7:0] vec_num, // vector
    input wire logic pec_steal, // stolen cycle
    input wire iec_pkg::iec_xfer_t pec_xfer // descriptor
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_vec_pulse;
        vec_valid |=> !vec_valid;
    endproperty
    a_vec_pulse: assert property (p_vec_pulse) else $error("vector pulse too long");
    property p_lat_fast;
        $rose(cpu_suspend) && $past(jump_cache) |-> !vec_valid[*7] ##1 vec_valid;
    endproperty
    a_lat_fast: assert property (p_lat_fast) else $error("short latency wrong");
    property p_lat_slow;
        $rose(cpu_suspend) && !$past(jump_cache) |-> ##11 vec_valid;
    endproperty
    a_lat_slow: assert property (p_lat_slow) else $error("long latency wrong");
    property p_susp_len;
        $rose(cpu_suspend) |-> cpu_suspend[*6];
    endproperty
    a_susp_len: assert property (p_susp_len) else $error("suspend dropped early");
    property p_susp_end;
        vec_valid |-> !cpu_suspend && $past(cpu_suspend);
    endproperty
    a_susp_end: assert property (p_susp_end) else $error("suspend not ended by vector");
    property p_steal_free;
        pec_steal |-> !cpu_suspend;
    endproperty
    a_steal_free: assert property (p_steal_free) else $error("transfer during suspend");
    property p_xfer_hold;
        !pec_steal |-> $stable(pec_xfer);
    endproperty
    a_xfer_hold: assert property (p_xfer_hold) else $error("descriptor moved");
    property p_vec_hold;
        !vec_valid |-> $stable(vec_num);
    endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
    property p_rd_idle;
        (!$past(reg_rd) || $past(reg_addr) >= 8'h80) |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    c_int: cover property (vec_valid && vec_num >= 8'h10);
    c_trap: cover property (vec_valid && vec_num < 8'h10);
    c_pec: cover property (pec_steal);
endmodule

bind iec_top iec_sva iec_sva_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .jump_cache(jump_cache), .cpu_suspend(cpu_suspend), .vec_valid(vec_valid),
    .vec_num(vec_num), .pec_steal(pec_steal), .pec_xfer(pec_xfer));

// *** tb/iec_cpu_model.sv ***
module iec_cpu_model (
    input wire logic clk, // clock
    input wire logic rst_n, // sync reset
    input wire logic vec_valid, // vector taken
    input wire logic [7:0] vec_num, // vector
    input wire logic [7:0] ret_delay, // handler length
    output logic trap_end // handler return pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic busy_r;
    // single level: a newer trap restarts the handler
    always_ff @(posedge clk) begin
        trap_end <= 1'b0;
        if (!rst_n) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
        end else if (vec_valid && vec_num < 8'h10) begin
            busy_r <= 1'b1;
            cnt_r <= ret_delay;
        end else if (busy_r && cnt_r == 8'h00) begin
            busy_r <= 1'b0;
            trap_end <= 1'b1;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule

// *** tb/iec_top_tb.sv ***
module iec_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, swi_valid = 1'b0;
    logic jump_cache = 1'b1, trap_end, cpu_suspend, vec_valid, pec_steal;
    logic [7:0] reg_addr = 8'h00, swi_num = 8'h00, vec_num, ret_delay = 8'h3c;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [83:0] src_req = '0;
    logic [31:0] sh_src = '0;
    logic [13:0] hw_trap = '0;
    logic [3:0] eru_pin = 4'h0, cpu_lvl = 4'h0, eru_out;
    logic [2:0] esr_pin = 3'h0;
    iec_pkg::iec_xfer_t pec_xfer;
    int errors = 0, total_checks = 0, n;
    logic [1:0] eru_e[4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic [1:0] eru_m[4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic eru_v[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic eru_x[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    always #12.5 clk = ~clk;
    iec_top iec_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .sh_src(sh_src),
        .eru_pin(eru_pin), .eru_out(eru_out), .hw_trap(hw_trap), .esr_pin(esr_pin), .swi_valid(swi_valid),
        .swi_num(swi_num), .cpu_lvl(cpu_lvl), .jump_cache(jump_cache), .trap_end(trap_end),
        .cpu_suspend(cpu_suspend), .vec_valid(vec_valid), .vec_num(vec_num), .pec_steal(pec_steal),
        .pec_xfer(pec_xfer));
    iec_cpu_model iec_cpu_model_i (.clk(clk), .rst_n(rst_n), .vec_valid(vec_valid), .vec_num(vec_num),
        .ret_delay(ret_delay), .trap_end(trap_end));
    task automatic chk(input string s, input logic [35:0] e, input logic [35:0] v);
        total_checks++;
        if (v !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask
    // one-cycle pulse on source, shared source or trap lines
    task automatic pulse(input int w, input logic [83:0] m);
        @(posedge clk);
        if (w == 0) src_req <= m;
        else if (w == 1) sh_src <= m[31:0];
        else hw_trap <= m[13:0];
        @(posedge clk);
        src_req <= '0;
        sh_src <= '0;
        hw_trap <= '0;
    endtask
    task automatic wait_ev(input int w, input int lim, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (((w == 0) ? vec_valid : (w == 1) ? pec_steal : eru_out[0]) !== 1'b1 && c < lim);
    endtask
    task automatic wait_vec(input logic [7:0] e);
        wait_ev(0, 300, n);
        chk("vec_valid", 1'b1, vec_valid);
        chk("vec_num", e, vec_num);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h05, 16'h0000);
        wr(8'h80, 16'hffff);
        rd(8'h80, 16'h0000);
        wr(8'h05, 16'h0033);
        wait_vec(8'h15);
        rd(8'h05, 16'h0013);
        @(posedge clk);
        jump_cache <= 1'b0;
        wr(8'h0a, 16'h0012);
        wr(8'h14, 16'h0016);
        pulse(0, (84'h1 << 10) | (84'h1 << 20));
        wait_vec(8'h24);
        wait_vec(8'h1a);
        @(posedge clk);
        jump_cache <= 1'b1;
        wr(8'h62, 16'h0302);
        wr(8'h6a, 16'h0100);
        wr(8'h72, 16'h0200);
        wr(8'h1e, 16'h0154);
        for (int k = 0; k < 2; k++) begin
            pulse(0, 84'h1 << 30);
            wait_ev(1, 20, n);
            chk("pec_xfer", {16'h0100 + 16'(2 * k), 16'h0200 + 16'(2 * k), 1'b0, 3'h2}, pec_xfer);
            @(negedge clk);
            chk("pec_steal", 1'b0, pec_steal);
            rd(8'h62, 16'h0301 - 16'(k));
        end
        wait_vec(8'h2e);
        rd(8'h72, 16'h0204);
        wr(8'h63, 16'h0d05);
        wr(8'h6b, 16'h0010);
        wr(8'h1f, 16'h01d4);
        pulse(0, 84'h1 << 31);
        wait_ev(1, 20, n);
        chk("pec_xfer", {16'h0010, 16'h0000, 1'b1, 3'h3}, pec_xfer);
        rd(8'h63, 16'h0d05);
        rd(8'h6b, 16'h0011);
        rd(8'h73, 16'h0000);
        wr(8'h78, 16'h0002);
        wr(8'h58, 16'h0015);
        pulse(1, 84'h2);
        rd(8'h58, 16'h0015);
        pulse(1, 84'h4);
        wait_vec(8'h68);
        pulse(2, 84'h8);
        wait_vec(8'h03);
        wr(8'h05, 16'h0033);
        pulse(2, 84'h200);
        wait_vec(8'h09);
        wait_vec(8'h15);
        chk("blocked", 1'b1, n > 60);
        rd(8'h7d, 16'h0208);
        wr(8'h7d, 16'h0208);
        rd(8'h7d, 16'h0000);
        @(posedge clk);
        ret_delay <= 8'h02;
        wr(8'h7e, 16'h0001);
        esr_pin[0] <= 1'b1;
        wait_vec(8'h0f);
        rd(8'h7d, 16'h8000);
        wr(8'h7e, 16'h0012);
        esr_pin[1] <= 1'b1;
        wait_vec(8'h0e);
        @(posedge clk);
        swi_num <= 8'h55;
        swi_valid <= 1'b1;
        @(posedge clk);
        swi_valid <= 1'b0;
        wait_vec(8'h55);
        wr(8'h7a, 16'h0001);
        wr(8'h7b, 16'h0002);
        for (int k = 0; k < 4; k++) begin
            wr(8'h79, {14'h0, eru_e[k]});
            wr(8'h7c, {14'h0, eru_m[k]});
            eru_pin[0] <= eru_v[k];
            wait_ev(2, 20, n);
            chk("eru_out", eru_x[k], n < 20);
        end
        complete_run();
    end
endmodule
